//--- ald_pkg.sv
package ald_pkg;

	// opcode patterns and masks of the accumulator load group
	localparam logic [7:0] OP_LOAD_ACC_IMM   = 8'h23;
	localparam logic [7:0] OP_LOAD_ACC_REG   = 8'hF8;
	localparam logic [7:0] MASK_REG          = 8'hF8;
	localparam logic [7:0] OP_LOAD_ACC_IND   = 8'hF0;
	localparam logic [7:0] MASK_IND          = 8'hFE;
	localparam logic [7:0] OP_LOAD_ACC_PSW   = 8'hC7;
	localparam logic [7:0] OP_LOAD_REG_IMM   = 8'hB8;

	// field positions inside an opcode
	localparam int         REG_SEL_MSB       = 2;
	localparam int         IND_SEL_BIT       = 0;

	// reset values
	localparam logic [7:0] ACC_RESET         = 8'h00;
	localparam logic [7:0] BYTE_ZERO         = 8'h00;
	localparam logic [2:0] REG_ZERO          = 3'h0;

	// fetch request toward the core: one program byte per machine cycle
	typedef struct packed {
		logic       valid;   // a byte is offered this cycle
		logic [7:0] data;    // program byte
	} ald_fetch_t;

	// register file write request
	typedef struct packed {
		logic       we;      // write strobe
		logic [2:0] sel;     // working register index
		logic [7:0] data;    // value written
	} ald_rf_wr_t;

endpackage : ald_pkg

//--- ald_decoder.sv
`timescale 1ns/1ps
module ald_decoder (
	input  wire logic              i_mclk,        // machine cycle clock
	input  wire logic              i_rst_n,       // synchronous reset, active low
	input  wire ald_pkg::ald_fetch_t i_fetch,     // program byte, one per machine cycle
	input  wire logic [7:0]        i_reg_rd_data, // working register read data
	input  wire logic [7:0]        i_mem_rd_data, // internal data memory read data
	input  wire logic [7:0]        i_program_status_word, // current status word
	output logic [2:0]             o_reg_rd_sel,  // working register read index
	output logic [7:0]             o_mem_addr,    // indirect data memory address
	output ald_pkg::ald_rf_wr_t    o_rf_wr,       // working register write
	output logic [7:0]             o_acc,         // accumulator
	output logic                   o_busy,        // second cycle of a two-byte form
	output logic                   o_done         // one pulse per completed instruction
);

	// sequencer states; ALD_IND covers both the register and the pointer read
	typedef enum logic [1:0] {
		ALD_IDLE,   // waiting for an opcode
		ALD_IND,    // register or data memory read completes here
		ALD_IMM     // waiting for the operand byte
	} ald_state_t;

	// sequencer state
	ald_state_t          state_reg;
	logic                imm_to_reg_reg;   // immediate goes to a working register
	logic [2:0]          imm_sel_reg;      // destination of the immediate
	logic                ind_read_reg;     // pending read goes through the pointer

	// result registers, each one drives one output
	logic [7:0]          acc_reg;          // accumulator
	logic [2:0]          rd_sel_reg;       // register read index
	ald_pkg::ald_rf_wr_t rf_wr_reg;        // register write request
	logic                done_reg;         // completion pulse
	logic                busy_reg;         // operand expected next
	logic [7:0]          mem_addr_reg;     // pointer value, informational

	// decode of the byte on the fetch path
	logic [7:0]          op;
	logic                is_acc_imm;
	logic                is_acc_reg;
	logic                is_acc_ind;
	logic                is_acc_psw;
	logic                is_reg_imm;

	// acceptance strobes shared by the processes below, all but the memory address
	logic                take_op;          // an opcode is accepted this cycle
	logic                take_imm;         // an operand byte is accepted
	logic                take_two;         // accepted opcode has an operand byte

	// opcode classification; only valid bytes in idle count as opcodes
	assign op         = i_fetch.data;
	assign is_acc_imm = (op == ald_pkg::OP_LOAD_ACC_IMM);
	assign is_acc_reg = ((op & ald_pkg::MASK_REG) == ald_pkg::OP_LOAD_ACC_REG);
	assign is_acc_ind = ((op & ald_pkg::MASK_IND) == ald_pkg::OP_LOAD_ACC_IND);
	assign is_acc_psw = (op == ald_pkg::OP_LOAD_ACC_PSW);
	assign is_reg_imm = ((op & ald_pkg::MASK_REG) == ald_pkg::OP_LOAD_REG_IMM);

	// acceptance: an opcode only in idle, an operand only while one is owed.
	// bytes offered during the read state are ignored, not queued
	assign take_op  = (state_reg == ALD_IDLE) && i_fetch.valid;
	assign take_imm = (state_reg == ALD_IMM) && i_fetch.valid;
	assign take_two = take_op && (is_acc_imm || is_reg_imm);

	// register read select: register rrr, or r0/r1 as pointer.
	// a registered select costs a cycle, so the register and pointer reads
	// complete on the edge after the opcode; that edge is still the single
	// machine cycle, as the fetch holds no new opcode until o_done
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rd_sel_reg <= ald_pkg::REG_ZERO;
		end else if (take_op) begin
			if (is_acc_ind) begin
				rd_sel_reg <= {2'h0, op[ald_pkg::IND_SEL_BIT]};
			end else begin
				rd_sel_reg <= op[ald_pkg::REG_SEL_MSB:0];
			end
		end
	end

	// remembers whether the pending read is a pointer read; kept apart from
	// the select so the accumulator mux needs no second decode of the opcode
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ind_read_reg <= 1'b0;
		end else if (take_op) begin
			ind_read_reg <= is_acc_ind;
		end
	end

	// sequencer
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_reg <= ALD_IDLE;
		end else begin
			case (state_reg)
				ALD_IDLE: begin
					if (take_two) begin
						state_reg <= ALD_IMM;
					end else if (take_op && (is_acc_reg || is_acc_ind)) begin
						state_reg <= ALD_IND;
					end
				end
				ALD_IND: begin
					state_reg <= ALD_IDLE;
				end
				ALD_IMM: begin
					// the sequencer waits as long as the operand is not offered
					if (i_fetch.valid) begin
						state_reg <= ALD_IDLE;
					end
				end
				default: begin
					state_reg <= ALD_IDLE;
				end
			endcase
		end
	end

	// destination of a pending immediate, captured with its opcode
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			imm_to_reg_reg <= 1'b0;
			imm_sel_reg    <= ald_pkg::REG_ZERO;
		end else if (take_two) begin
			imm_to_reg_reg <= is_reg_imm;
			imm_sel_reg    <= op[ald_pkg::REG_SEL_MSB:0];
		end
	end

	// accumulator; status flags are never written by this group
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			acc_reg <= ald_pkg::ACC_RESET;
		end else begin
			case (state_reg)
				ALD_IDLE: begin
					if (take_op && is_acc_psw) begin
						acc_reg <= i_program_status_word;
					end
				end
				ALD_IND: begin
					// memory data must already follow the pointer in this cycle
					if (ind_read_reg) begin
						acc_reg <= i_mem_rd_data;
					end else begin
						acc_reg <= i_reg_rd_data;
					end
				end
				ALD_IMM: begin
					if (i_fetch.valid && !imm_to_reg_reg) begin
						acc_reg <= i_fetch.data;
					end
				end
				default: begin
					acc_reg <= acc_reg;
				end
			endcase
		end
	end

	// working register write for the immediate form; sel and data run free,
	// only the strobe qualifies them, which saves enables on eleven bits
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rf_wr_reg <= '0;
		end else begin
			rf_wr_reg.we   <= take_imm && imm_to_reg_reg;
			rf_wr_reg.sel  <= imm_sel_reg;
			rf_wr_reg.data <= i_fetch.data;
		end
	end

	// completion pulse, one per instruction
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= (state_reg == ALD_IND)
				|| take_imm
				|| (take_op && is_acc_psw);
		end
	end

	// memory address follows the pointer register read; it lags one cycle,
	// so the core decodes its own pointer for the read data
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			mem_addr_reg <= ald_pkg::BYTE_ZERO;
		end else begin
			mem_addr_reg <= i_reg_rd_data;
		end
	end

	// busy marks the first cycle in which the operand byte is owed
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= take_two;
		end
	end

	// every output comes straight from its flip-flop
	assign o_reg_rd_sel = rd_sel_reg;
	assign o_mem_addr   = mem_addr_reg;
	assign o_rf_wr      = rf_wr_reg;
	assign o_acc        = acc_reg;
	assign o_busy       = busy_reg;
	assign o_done       = done_reg;

endmodule : ald_decoder

//--- ald_decoder_chk.sv
`timescale 1ns/1ps
module ald_decoder_chk (
	input wire logic                i_mclk,
	input wire logic                i_rst_n,
	input wire ald_pkg::ald_fetch_t i_fetch,
	input wire logic [7:0]          i_reg_rd_data,
	input wire logic [7:0]          i_mem_rd_data,
	input wire logic [7:0]          i_program_status_word,
	input wire logic [2:0]          o_reg_rd_sel,
	input wire ald_pkg::ald_rf_wr_t o_rf_wr,
	input wire logic [7:0]          o_acc,
	input wire logic                o_busy,
	input wire logic                o_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	logic       act_reg; // instruction in flight
	logic [7:0] d;
	logic       take;
	assign d = i_fetch.data;
	assign take = i_fetch.valid && !act_reg && (d == 8'h23 || d == 8'hC7
		|| d[7:3] == 5'h1F || d[7:1] == 7'h78 || d[7:3] == 5'h17);
	// bytes offered mid-instruction are not opcodes, so track one in flight
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || o_done) act_reg <= 1'b0;
		else if (take) act_reg <= 1'b1;
	end
	sequence s_two; o_busy && !o_done ##1 o_done && !o_busy; endsequence
	property p_psw; take && d == 8'hC7 |=> o_done && o_acc == $past(i_program_status_word);
	endproperty
	a_psw: assert property (p_psw) else $error("status word load wrong");
	property p_imm; take && d == 8'h23 |=> s_two ##0 o_acc == $past(d); endproperty
	a_imm: assert property (p_imm) else $error("immediate load wrong");
	property p_reg; take && d[7:3] == 5'h1F |=> o_reg_rd_sel == $past(d[2:0])
		##1 o_done && o_acc == $past(i_reg_rd_data); endproperty
	a_reg: assert property (p_reg) else $error("register copy wrong");
	property p_ind; take && d[7:1] == 7'h78 |=> o_reg_rd_sel == {2'h0, $past(d[0])}
		##1 o_done && o_acc == $past(i_mem_rd_data); endproperty
	a_ind: assert property (p_ind) else $error("indirect load wrong");
	property p_rf; take && d[7:3] == 5'h17 |=> s_two ##0 o_rf_wr.we && $stable(o_acc)
		&& o_rf_wr.sel == $past(d[2:0], 2) && o_rf_wr.data == $past(d); endproperty
	a_rf: assert property (p_rf) else $error("register immediate wrong");
	property p_we; o_rf_wr.we |-> o_done && $past(o_busy); endproperty
	a_we: assert property (p_we) else $error("stray register write");
	property p_hold; !o_done |-> $stable(o_acc); endproperty
	a_hold: assert property (p_hold) else $error("accumulator moved");
	property p_busy; o_busy |=> !o_busy; endproperty
	a_busy: assert property (p_busy) else $error("busy longer than one cycle");
endmodule : ald_decoder_chk
bind ald_decoder ald_decoder_chk u_chk (.*);

//--- test_accumulator_load_decoder.sv
`timescale 1ns/1ps
module test_accumulator_load_decoder;
	logic                i_mclk = 1'b0;
	logic                i_rst_n = 1'b0;
	ald_pkg::ald_fetch_t i_fetch = '0;
	logic [7:0]          program_status_word = 8'h00;
	logic [7:0]          regs [8];
	logic [7:0]          rd, acc, acc_m, op, maddr;
	logic [2:0]          sel;
	ald_pkg::ald_rf_wr_t wr;
	logic                busy, done;
	int                  miscompares = 0, num_checks = 0, seed = 38;
	always #4 i_mclk = ~i_mclk;
	assign rd = regs[sel];
	// data memory stand-in: a fixed scramble of the pointer's register
	ald_decoder u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_fetch(i_fetch),
		.i_reg_rd_data(rd), .i_mem_rd_data(rd ^ 8'hA5), .i_program_status_word(program_status_word),
		.o_reg_rd_sel(sel), .o_mem_addr(maddr), .o_rf_wr(wr), .o_acc(acc), .o_busy(busy),
		.o_done(done));
	function automatic logic known(logic [7:0] o);
		return o == 8'h23 || o == 8'hC7 || o[7:3] == 5'h1F || o[7:1] == 7'h78 || o[7:3] == 5'h17;
	endfunction : known
	function automatic logic [7:0] exp_acc(logic [7:0] o, logic [7:0] imm);
		if (o == 8'h23) return imm;
		if (o == 8'hC7) return program_status_word;
		if (o[7:3] == 5'h1F) return regs[o[2:0]];
		if (o[7:1] == 7'h78) return regs[{2'h0, o[0]}] ^ 8'hA5;
		return acc_m;
	endfunction : exp_acc
	task automatic chk_acc(logic [7:0] got, logic [7:0] e);
		num_checks++;
		if (got !== e) begin
			miscompares++;
			$display("Error %0t acc %h exp %h", $time, got, e);
		end
	endtask : chk_acc
	task automatic chk_wr(ald_pkg::ald_rf_wr_t got, ald_pkg::ald_rf_wr_t e);
		num_checks++;
		if (got !== e) begin
			miscompares++;
			$display("Error %0t write %h exp %h", $time, got, e);
		end
	endtask : chk_wr
	task automatic chk_addr(logic [7:0] got, logic [7:0] e);
		num_checks++;
		if (got !== e) begin
			miscompares++;
			$display("Error %0t address %h exp %h", $time, got, e);
		end
	endtask : chk_addr
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	// one instruction: opcode, optional operand, then wait for completion
	task automatic run(logic [7:0] o, logic [7:0] imm);
		int n;
		@(posedge i_mclk);
		program_status_word <= 8'($random(seed));
		i_fetch <= {1'b1, o};
		if (o == 8'h23 || o[7:3] == 5'h17) begin
			@(posedge i_mclk);
			i_fetch <= {1'b1, imm};
		end
		@(posedge i_mclk);
		i_fetch <= {1'b0, ~imm}; // bus no longer shows the operand
		// look between edges so done and acc are settled, never racing the launch
		@(negedge i_mclk);
		for (n = 0; n < 8 && done !== 1'b1; n++) @(negedge i_mclk);
		num_checks++;
		if (done !== 1'b1) begin
			miscompares++;
			$display("Error %0t no completion for op %h", $time, o);
		end
		chk_acc(acc, exp_acc(o, imm));
		if (o[7:1] == 7'h78) chk_addr(maddr, regs[{2'h0, o[0]}]);
		if (o[7:3] == 5'h17) chk_wr(wr, {1'b1, o[2:0], imm});
		else chk_wr({wr.we, 11'h000}, '0);
		if (o[7:3] == 5'h17) regs[o[2:0]] = imm;
		acc_m = exp_acc(o, imm);
		$display("op %h finished", o);
	endtask : run
	initial begin
		foreach (regs[i]) regs[i] = 8'($random(seed));
		acc_m = 8'h00;
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		run(8'h23, 8'hFF);
		run(8'hBF, 8'h00);
		for (int i = 0; i < 256; i++) if (known(8'(i))) run(8'(i), 8'($random(seed)));
		repeat (60) begin
			do op = 8'($random(seed)); while (!known(op));
			run(op, 8'($random(seed)));
		end
		tally_and_finish();
	end
	initial begin
		#80000;
		miscompares++;
		tally_and_finish();
	end
endmodule : test_accumulator_load_decoder
